// ### rtl/slc_pkg.sv
// shared constants and types for the serial link setup block
// assumes a single 250 MHz core clock and rear switches that read 1 when closed
package slc_pkg;

  // core clock and bit-rate timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int BASE_RATE_BPS = 75;
  // cycles per bit at the slowest rate, rounded down
  localparam int BASE_BIT_CYCLES = CLK_HZ / BASE_RATE_BPS;
  localparam int BIT_CNT_W = 22;
  localparam int RATE_CODE_W = 3;

  // receive buffer shape and pacing thresholds
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_LEVEL_W = 3;
  localparam logic [2:0] FIFO_ALMOST_FULL = 3'h3;
  localparam logic [2:0] FIFO_ALMOST_EMPTY = 3'h1;

  // characters on the wire
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_SEMI = 8'h3b;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_DOT = 8'h2e;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;
  localparam logic [7:0] CHAR_LOW_A = 8'h61;
  localparam logic [7:0] CHAR_LOW_Z = 8'h7a;
  localparam logic [7:0] CASE_OFFSET = 8'h20;

  // command words, upper case, last four letters seen
  localparam logic [31:0] WORD_VOLT = 32'h56534554;
  localparam logic [31:0] WORD_CURR = 32'h49534554;

  // register map, byte addresses
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_VOLT = 4'h4;
  localparam logic [3:0] REG_CURR = 4'h8;
  localparam logic [3:0] REG_CONTROL = 4'hc;

  // config/status field positions
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_FLOW_BIT = 3;
  localparam int CFG_HW_BIT = 4;
  localparam int CFG_LOCAL_BIT = 5;
  localparam int CFG_REMOTE_BIT = 6;
  localparam int CFG_OVERRUN_BIT = 7;
  localparam int CFG_DONE_BIT = 8;
  // control field positions
  localparam int CTL_REMOTE_BIT = 0;
  localparam int CTL_CLR_OVR_BIT = 1;

  // reset values and the saturation ceiling for parsed numbers
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] VALUE_MAX = 16'hffff;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // switch settings caught once after reset
  typedef struct packed {
    logic [2:0] rateCode;
    logic flowOn;
    logic hwPacing;
    logic localStart;
  } slc_cfg_type;

  // command parser states, gray along word -> number -> apply
  typedef enum logic [1:0] {
    P_WORD = 2'b00,
    P_NUM = 2'b01,
    P_APPLY = 2'b11,
    P_SKIP = 2'b10
  } slc_parse_type;

endpackage

// ### rtl/slc_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes depth is a power of two; level counts words held
`timescale 1ns/1ns
module slc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int LEVEL_W = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [LEVEL_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = LEVEL_W'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];  // word storage
  logic [PTR_W-1:0] wrPtr;  // next slot to fill
  logic [PTR_W-1:0] rdPtr;  // oldest word
  logic doPush;
  logic doPop;

  // full and empty come straight from the count, so they never lie
  assign inReady = (level != LEVEL_FULL);
  assign outValid = (level != '0);
  assign outData = store[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  // pointers and level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= PTR_W'(wrPtr + 1'b1);
      end
      if (doPop) begin
        rdPtr <= PTR_W'(rdPtr + 1'b1);
      end
      if (doPush && !doPop) begin
        level <= LEVEL_W'(level + 1'b1);
      end else if (doPop && !doPush) begin
        level <= LEVEL_W'(level - 1'b1);
      end
    end
  end

endmodule

// ### rtl/slc_serial_link.sv
// serial command port: switch setup, receiver, pacing, command parser, register slave
// assumes rear switches and the receive line are asynchronous pins
// Notes on behaviour
// [RULE1] host and device share one bit rate
// [RULE2] rate is 75 shifted by switch code
// [RULE3] switches sampled only once after power-up
// [RULE4] pacing switch turns flow control on/off
// [RULE5] flow method: characters or handshake line
// [RULE6] startup switch picks remote or local control
// [RULE7] remote startup lights the remote indicator
// [RULE8] semicolon commands set voltage and current
// [RULE9] send XOFF when full, XON when ready
// [RULE10] handshake output shows readiness to receive
// [RULE11] startup switch 0 remote, 1 local
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
module slc_serial_link #(
  parameter int BASE_BIT_CYCLES = slc_pkg::BASE_BIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // rear switch bank
  input wire logic rateSelectWeightFour,
  input wire logic rateSelectWeightTwo,
  input wire logic rateSelectWeightOne,
  input wire logic flowDisableSwitch,
  input wire logic hwPacingSwitch,
  input wire logic startupModeSwitch,
  // serial port connector
  input wire logic rxData,
  output logic txData,
  output logic deviceReadyOut,
  // front panel
  output logic remoteLed,
  // power stage
  input wire logic applyReady,
  output logic [15:0] voltSetpoint,
  output logic [15:0] currSetpoint,
  // avalon-mm slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest
);

  // character helpers shared by the parser branches
  function automatic logic isDigit(input logic [7:0] ch);
    return (ch >= slc_pkg::CHAR_ZERO) && (ch <= slc_pkg::CHAR_NINE);
  endfunction

  function automatic logic isTerm(input logic [7:0] ch);
    return (ch == slc_pkg::CHAR_SEMI) || (ch == slc_pkg::CHAR_CR) || (ch == slc_pkg::CHAR_LF);
  endfunction

  function automatic logic [7:0] toUpper(input logic [7:0] ch);
    logic [7:0] res;
    res = ch;
    if ((ch >= slc_pkg::CHAR_LOW_A) && (ch <= slc_pkg::CHAR_LOW_Z)) begin
      res = ch - slc_pkg::CASE_OFFSET;
    end
    return res;
  endfunction

  // decimal accumulate, saturating so a long number cannot wrap to a small one
  function automatic logic [15:0] accumDigit(input logic [15:0] acc, input logic [7:0] ch);
    logic [19:0] wide;
    wide = {4'h0, acc} * 20'h0000a + {16'h0000, ch[3:0]};
    if (wide > {4'h0, slc_pkg::VALUE_MAX}) begin
      return slc_pkg::VALUE_MAX;
    end
    return wide[15:0];
  endfunction

  // pin synchronisers
  logic [5:0] swMeta;  // first stage, read only by swSync
  logic [5:0] swSync;
  logic rxMeta;  // first stage, read only by rxSync
  logic rxSync;
  logic rxPrev;  // for start-bit edge

  // setup state
  slc_pkg::slc_cfg_type cfg;  // frozen switch settings
  logic cfgDone;  // high once settings are caught
  logic [slc_pkg::BIT_CNT_W-1:0] bitCycles;  // cycles per bit
  logic [slc_pkg::BIT_CNT_W-1:0] halfCycles;  // half a bit, to land mid-bit

  // receiver
  logic rxBusy;
  logic [slc_pkg::BIT_CNT_W-1:0] rxCnt;
  logic [3:0] rxBitIdx;
  logic [7:0] rxShift;
  logic rxStrobe;  // one-cycle pulse, a byte with good stop bit
  logic overrun;  // sticky: byte lost to a full buffer

  // buffer
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic [2:0] fifoLevel;
  logic parseReady;

  // transmitter and pacing
  logic txBusy;
  logic [slc_pkg::BIT_CNT_W-1:0] txCnt;
  logic [3:0] txBitIdx;
  logic [8:0] txShift;  // stop bit over character
  logic xoffSent;  // host has been told to pause
  logic softPacing;
  logic sendXoff;
  logic sendXon;

  // parser
  slc_pkg::slc_parse_type parseState;
  logic [31:0] wordBuf;  // last four letters, upper case
  logic [15:0] acc;  // number being read
  logic fracSeen;  // digits after a point are dropped
  logic isVolt;  // pending command targets voltage
  logic take;

  // bus
  logic busReq;
  logic busWrite;
  logic [31:0] readValue;

  // switches and line pass two flops before anything looks at them
  always_ff @(posedge ref_clk) begin
    swMeta <= {rateSelectWeightFour, rateSelectWeightTwo, rateSelectWeightOne,
               flowDisableSwitch, hwPacingSwitch, startupModeSwitch};
    swSync <= swMeta;
    rxMeta <= rxData;
    rxSync <= rxMeta;
  end

  // catch the switches once, on the first edge after reset; later moves are ignored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg <= '0;
      cfgDone <= 1'b0;
    end else if (!cfgDone) begin
      cfg.rateCode <= swSync[5:3];  // [RULE2] [RULE3]
      cfg.flowOn <= !swSync[2];  // [RULE4]
      cfg.hwPacing <= swSync[1];  // [RULE5]
      cfg.localStart <= swSync[0];  // [RULE6]
      cfgDone <= 1'b1;  // [RULE3]
    end
  end

  // one divisor serves receive and transmit, so both run the host's rate
  assign bitCycles = slc_pkg::BIT_CNT_W'(BASE_BIT_CYCLES >> cfg.rateCode);  // [RULE1] [RULE2]
  assign halfCycles = bitCycles >> 1;

  // receiver: centre-sample start, eight data bits, stop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rxPrev <= 1'b1;
      rxBusy <= 1'b0;
      rxCnt <= '0;
      rxBitIdx <= 4'h0;
      rxShift <= 8'h00;
      rxStrobe <= 1'b0;
    end else begin
      rxPrev <= rxSync;
      rxStrobe <= 1'b0;
      if (!rxBusy) begin
        // falling edge marks a start bit; nothing heard before setup is done
        if (cfgDone && rxPrev && !rxSync) begin
          rxBusy <= 1'b1;
          rxCnt <= halfCycles;
          rxBitIdx <= 4'h0;
        end
      end else if (rxCnt != '0) begin
        rxCnt <= rxCnt - 1'b1;
      end else begin
        rxCnt <= bitCycles - 1'b1;
        rxBitIdx <= rxBitIdx + 4'h1;
        if (rxBitIdx == 4'h0) begin
          // glitch, not a start bit
          if (rxSync) begin
            rxBusy <= 1'b0;
          end
        end else if (rxBitIdx <= 4'h8) begin
          rxShift <= {rxSync, rxShift[7:1]};
        end else begin
          // framing errors are dropped silently
          rxBusy <= 1'b0;
          rxStrobe <= rxSync;
        end
      end
    end
  end

  // overrun flag; a new loss in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overrun <= 1'b0;
    end else if (rxStrobe && !fifoInReady) begin
      overrun <= 1'b1;
    end else if (busWrite && avsAddress == slc_pkg::REG_CONTROL && avsByteEnable[0]
                 && avsWriteData[slc_pkg::CTL_CLR_OVR_BIT]) begin
      overrun <= 1'b0;
    end
  end

  // received bytes wait here while the parser is stalled on the power stage
  slc_fifo #(
    .WIDTH(slc_pkg::FIFO_WIDTH),
    .DEPTH(slc_pkg::FIFO_DEPTH),
    .LEVEL_W(slc_pkg::FIFO_LEVEL_W)
  ) rxFifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .inValid(rxStrobe),
    .inReady(fifoInReady),
    .inData(rxShift),
    .outValid(fifoOutValid),
    .outReady(parseReady),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // xoff goes out one word early since a byte may already be on the wire
  assign softPacing = cfgDone && cfg.flowOn && !cfg.hwPacing;  // [RULE4] [RULE5]
  assign sendXoff = softPacing && !txBusy && !xoffSent
                    && (fifoLevel >= slc_pkg::FIFO_ALMOST_FULL);  // [RULE9]
  assign sendXon = softPacing && !txBusy && xoffSent
                   && (fifoLevel <= slc_pkg::FIFO_ALMOST_EMPTY);  // [RULE9]

  // transmitter: only pacing characters leave the device here
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txData <= 1'b1;
      txBusy <= 1'b0;
      txCnt <= '0;
      txBitIdx <= 4'h0;
      txShift <= 9'h1ff;
    end else if (!txBusy) begin
      if (sendXoff || sendXon) begin
        txShift <= {1'b1, sendXoff ? slc_pkg::CHAR_XOFF : slc_pkg::CHAR_XON};  // [RULE9]
        txData <= 1'b0;
        txBusy <= 1'b1;
        txCnt <= bitCycles - 1'b1;
        txBitIdx <= 4'h0;
      end
    end else if (txCnt != '0) begin
      txCnt <= txCnt - 1'b1;
    end else if (txBitIdx == 4'h9) begin
      txBusy <= 1'b0;
    end else begin
      txData <= txShift[0];
      txShift <= {1'b1, txShift[8:1]};
      txBitIdx <= txBitIdx + 4'h1;
      txCnt <= bitCycles - 1'b1;
    end
  end

  // remembers whether the host is paused
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xoffSent <= 1'b0;
    end else if (sendXoff) begin
      xoffSent <= 1'b1;
    end else if (sendXon) begin
      xoffSent <= 1'b0;
    end
  end

  // handshake line: low until setup is done, then only meaningful in hardware pacing, held high otherwise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      deviceReadyOut <= 1'b0;
    end else if (!cfgDone) begin
      deviceReadyOut <= 1'b0;
    end else if (!cfg.flowOn || !cfg.hwPacing) begin
      deviceReadyOut <= 1'b1;  // [RULE4]
    end else begin
      deviceReadyOut <= (fifoLevel < slc_pkg::FIFO_ALMOST_FULL);  // [RULE10]
    end
  end

  // remote/local: caught at startup, software may switch it later
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      remoteLed <= 1'b0;
    end else if (!cfgDone) begin
      remoteLed <= !swSync[0];  // [RULE6] [RULE7] [RULE11]
    end else if (busWrite && avsAddress == slc_pkg::REG_CONTROL && avsByteEnable[0]) begin
      remoteLed <= avsWriteData[slc_pkg::CTL_REMOTE_BIT];
    end
  end

  // parser drains the buffer except while a setpoint waits on the power stage
  assign parseReady = (parseState != slc_pkg::P_APPLY);
  assign take = fifoOutValid && parseReady;

  // command parser: word, number, terminator, apply
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      parseState <= slc_pkg::P_WORD;
      wordBuf <= 32'h00000000;
      acc <= slc_pkg::SETPOINT_RST;
      fracSeen <= 1'b0;
      isVolt <= 1'b0;
      voltSetpoint <= slc_pkg::SETPOINT_RST;
      currSetpoint <= slc_pkg::SETPOINT_RST;
    end else begin
      case (parseState)
        slc_pkg::P_WORD: begin
          if (take) begin
            if (isTerm(fifoOutData)) begin
              wordBuf <= 32'h00000000;  // [RULE8]
            end else if (isDigit(fifoOutData)) begin
              if (wordBuf == slc_pkg::WORD_VOLT || wordBuf == slc_pkg::WORD_CURR) begin
                isVolt <= (wordBuf == slc_pkg::WORD_VOLT);
                acc <= accumDigit(16'h0000, fifoOutData);
                fracSeen <= 1'b0;
                parseState <= slc_pkg::P_NUM;
              end else begin
                parseState <= slc_pkg::P_SKIP;
              end
            end else if (fifoOutData != slc_pkg::CHAR_SPACE) begin
              wordBuf <= {wordBuf[23:0], toUpper(fifoOutData)};
            end
          end
        end
        slc_pkg::P_NUM: begin
          if (take) begin
            if (isDigit(fifoOutData)) begin
              // fraction digits are read but not kept
              if (!fracSeen) begin
                acc <= accumDigit(acc, fifoOutData);
              end
            end else if (fifoOutData == slc_pkg::CHAR_DOT) begin
              fracSeen <= 1'b1;
            end else if (isTerm(fifoOutData)) begin
              parseState <= slc_pkg::P_APPLY;  // [RULE8]
            end else if (fifoOutData != slc_pkg::CHAR_SPACE) begin
              parseState <= slc_pkg::P_SKIP;
            end
          end
        end
        slc_pkg::P_APPLY: begin
          if (applyReady) begin
            // local mode: commands are read and discarded
            if (remoteLed && isVolt) begin
              voltSetpoint <= acc;  // [RULE8]
            end else if (remoteLed) begin
              currSetpoint <= acc;  // [RULE8]
            end
            wordBuf <= 32'h00000000;
            parseState <= slc_pkg::P_WORD;
          end
        end
        slc_pkg::P_SKIP: begin
          if (take && isTerm(fifoOutData)) begin
            wordBuf <= 32'h00000000;
            parseState <= slc_pkg::P_WORD;
          end
        end
        default: begin
          parseState <= slc_pkg::P_WORD;
        end
      endcase
    end
  end

  // bus slave: one wait cycle, then answer; a write lands when waitrequest is low
  assign busReq = avsRead || avsWrite;
  assign busWrite = avsWrite && !avsWaitRequest;

  // read mux; unmapped offsets read zero
  always_comb begin
    readValue = slc_pkg::READ_ZERO;
    case (avsAddress)
      slc_pkg::REG_CONFIG: begin
        readValue[slc_pkg::CFG_RATE_LSB +: slc_pkg::RATE_CODE_W] = cfg.rateCode;
        readValue[slc_pkg::CFG_FLOW_BIT] = cfg.flowOn;
        readValue[slc_pkg::CFG_HW_BIT] = cfg.hwPacing;
        readValue[slc_pkg::CFG_LOCAL_BIT] = cfg.localStart;
        readValue[slc_pkg::CFG_REMOTE_BIT] = remoteLed;
        readValue[slc_pkg::CFG_OVERRUN_BIT] = overrun;
        readValue[slc_pkg::CFG_DONE_BIT] = cfgDone;
      end
      slc_pkg::REG_VOLT: readValue[15:0] = voltSetpoint;
      slc_pkg::REG_CURR: readValue[15:0] = currSetpoint;
      slc_pkg::REG_CONTROL: readValue[slc_pkg::CTL_REMOTE_BIT] = remoteLed;
      default: readValue = slc_pkg::READ_ZERO;
    endcase
  end

  // waitrequest and read data registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= slc_pkg::READ_ZERO;
    end else if (busReq && avsWaitRequest) begin
      avsWaitRequest <= 1'b0;
      avsReadData <= avsRead ? readValue : slc_pkg::READ_ZERO;
    end else begin
      avsWaitRequest <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_rate_divide: assert property (cfgDone |-> // [RULE2]
      ((int'(bitCycles) << cfg.rateCode) <= BASE_BIT_CYCLES)
      && (((int'(bitCycles) + 1) << cfg.rateCode) > BASE_BIT_CYCLES))
    else $error("bit period does not match switch code");
  a_config_frozen: assert property (cfgDone && $past(cfgDone) |-> $stable(cfg)) // [RULE3]
    else $error("settings changed after startup");
  a_no_flow_idle: assert property ($past(cfgDone) && !cfg.flowOn // [RULE4]
      |-> !txBusy && deviceReadyOut)
    else $error("pacing active with flow control off");
  a_soft_line_high: assert property ($past(cfgDone) && cfg.flowOn && !cfg.hwPacing // [RULE5]
      |-> deviceReadyOut)
    else $error("handshake line dropped in character pacing");
  a_xoff_char: assert property (sendXoff |=> txBusy && !txData // [RULE9]
      && txShift[7:0] == slc_pkg::CHAR_XOFF && xoffSent)
    else $error("xoff not sent when buffer full");
  a_xon_char: assert property (sendXon // [RULE9]
      |=> txShift[7:0] == slc_pkg::CHAR_XON && !xoffSent)
    else $error("xon not sent when buffer drained");
  a_hw_ready_low: assert property (cfgDone && cfg.flowOn && cfg.hwPacing // [RULE10]
      && fifoLevel >= slc_pkg::FIFO_ALMOST_FULL |=> !deviceReadyOut)
    else $error("handshake line high with full buffer");
  a_startup_mode: assert property (!cfgDone |=> remoteLed == !$past(swSync[0])) // [RULE11]
    else $error("startup mode wrong");
  a_apply_volt: assert property (parseState == slc_pkg::P_APPLY && applyReady // [RULE8]
      && remoteLed && isVolt |=> voltSetpoint == $past(acc) && parseState == slc_pkg::P_WORD)
    else $error("voltage command not applied");
  a_bus_answer: assert property (busReq && avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest)
    else $error("bus answer not one cycle after request");

  c_xoff_sent: cover property (sendXoff);
  c_volt_applied: cover property (parseState == slc_pkg::P_APPLY && applyReady && isVolt);
  c_remote_start: cover property ($rose(cfgDone) && remoteLed);
  c_hw_not_ready: cover property (cfg.hwPacing && cfg.flowOn && $fell(deviceReadyOut));

endmodule

// ### bench/slc_host_port.sv
// host serial port model: sends 8N1 frames and logs the frames the device sends back
// assumes the bench sets bitCycles to the rate picked on the rate switches
`timescale 1ns/1ns
module slc_host_port (
  // clock
  input wire logic ref_clk,
  // cycles per bit
  input wire logic [31:0] bitCycles,
  // serial lines
  output logic hostTx,
  input wire logic hostRx
);
  logic [7:0] rxLog[$]; // frames seen from the device
  logic [7:0] rxByte; // frame being assembled
  // line idles high between frames, never floats
  initial hostTx = 1'b1;
  // one frame, lsb first, at the rate both ends share
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      hostTx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (bitCycles - 1) @(posedge ref_clk);
    end
  endtask
  // sample at bit centres; a frame without a stop bit is not logged
  always begin
    @(negedge hostRx);
    repeat (bitCycles / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCycles) @(posedge ref_clk);
      rxByte[i] = hostRx;
    end
    repeat (bitCycles) @(posedge ref_clk);
    if (hostRx === 1'b1) rxLog.push_back(rxByte);
  end
endmodule

// ### bench/tb_slc_serial_link.sv
// top bench: switch capture, command traffic, pacing characters, register access
// assumes the rate base is cut to 1024 cycles, so code 7 gives 8-cycle bits
`timescale 1ns/1ns
module tb_slc_serial_link;
  // clock, reset, switches and power stage
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] rateCode = 3'h7;
  logic flowDisableSwitch = 1'b0;
  logic hwPacingSwitch = 1'b0;
  logic startupModeSwitch = 1'b0;
  logic applyReady = 1'b1;
  logic rxData, txData, deviceReadyOut, remoteLed;
  logic [15:0] voltSetpoint, currSetpoint;
  // register bus
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [3:0] avsByteEnable = 4'hf;
  logic [31:0] avsReadData, rd;
  logic avsWaitRequest;
  int bitCycles = 8; // 1024 >> 7
  int n_fail = 0;
  int samples_checked = 0;
  slc_serial_link #(.BASE_BIT_CYCLES(1024)) slc_serial_link_i (.ref_clk(ref_clk), .srst(srst),
    .rateSelectWeightFour(rateCode[2]), .rateSelectWeightTwo(rateCode[1]),
    .rateSelectWeightOne(rateCode[0]), .flowDisableSwitch(flowDisableSwitch),
    .hwPacingSwitch(hwPacingSwitch), .startupModeSwitch(startupModeSwitch), .rxData(rxData),
    .txData(txData), .deviceReadyOut(deviceReadyOut), .remoteLed(remoteLed),
    .applyReady(applyReady), .voltSetpoint(voltSetpoint), .currSetpoint(currSetpoint),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));
  slc_host_port slc_host_port_i (.ref_clk(ref_clk), .bitCycles(bitCycles), .hostTx(rxData),
    .hostRx(txData));
  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  // verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bus transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= wd;
    // no cycle count assumed; the wait ends when waitrequest is seen low, or at the hang guard if it never is
    do begin
      @(posedge ref_clk);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  // switches settle during the 8-cycle reset; 3 edges after it the outputs are valid
  task automatic do_reset;
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) slc_host_port_i.send_byte(s[i]);
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      rateCode <= i[2:0];
      hwPacingSwitch <= i[0];
      flowDisableSwitch <= i[1];
      startupModeSwitch <= i[2];
      do_reset();
      bus(1'b0, slc_pkg::REG_CONFIG, 32'h0);
      check("rate", rd[2:0], i[2:0]);
      check("flow", rd[3], !i[1]);
      check("method", rd[4], i[0]);
      check("mode", rd[8:5], {2'b10, !i[2], i[2]});
      check("led", remoteLed, !i[2]);
      if (i[1:0] == 2'b01) check("ready", deviceReadyOut, 1'b1);
    end
    // later switch changes are ignored
    rateCode <= 3'h0;
    flowDisableSwitch <= 1'b0;
    startupModeSwitch <= 1'b0;
    hwPacingSwitch <= 1'b0;
    repeat (10) @(posedge ref_clk);
    bus(1'b0, slc_pkg::REG_CONFIG, 32'h0);
    check("held", rd[5:0], 6'h37);
    $display("test switch capture done");
    rateCode <= 3'h7;
    do_reset();
    check("led", remoteLed, 1'b1);
    send_str("VSET2;ISET1;");
    repeat (40) @(posedge ref_clk);
    check("volt", voltSetpoint, 16'h0002);
    check("curr", currSetpoint, 16'h0001);
    // stall the parser so the buffer fills; the fifth space is refused
    applyReady <= 1'b0;
    send_str("VSET5;     ");
    repeat (200) @(posedge ref_clk);
    bus(1'b0, slc_pkg::REG_CONFIG, 32'h0);
    check("overrun", rd[7], 1'b1);
    applyReady <= 1'b1;
    repeat (300) @(posedge ref_clk);
    check("volt", voltSetpoint, 16'h0005);
    check("xoff", slc_host_port_i.rxLog[0], slc_pkg::CHAR_XOFF);
    check("xon", slc_host_port_i.rxLog[1], slc_pkg::CHAR_XON);
    bus(1'b0, slc_pkg::REG_VOLT, 32'h0);
    check("volt reg", rd, 32'h00000005);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    // one write goes to local mode and clears the loss flag
    bus(1'b1, slc_pkg::REG_CONTROL, 32'h00000002);
    bus(1'b0, slc_pkg::REG_CONFIG, 32'h0);
    check("cleared", rd[7:6], 2'b00);
    send_str("ISET9;");
    repeat (40) @(posedge ref_clk);
    check("local", {remoteLed, currSetpoint}, 17'h00001);
    $display("test traffic and pacing done");
    // handshake pacing: line drops with three bytes held, rises once drained
    hwPacingSwitch <= 1'b1;
    applyReady <= 1'b0;
    do_reset();
    send_str("VSET1;   ");
    repeat (20) @(posedge ref_clk);
    check("ready", deviceReadyOut, 1'b0);
    applyReady <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check("ready", deviceReadyOut, 1'b1);
    check("volt", voltSetpoint, 16'h0001);
    $display("test handshake pacing done");
    // pacing off: no characters and the line stays up even when the buffer fills
    flowDisableSwitch <= 1'b1;
    applyReady <= 1'b0;
    do_reset();
    send_str("VSET1;     ");
    repeat (200) @(posedge ref_clk);
    check("quiet", slc_host_port_i.rxLog.size(), 2);
    check("ready", deviceReadyOut, 1'b1);
    $display("test pacing off done");
    results();
  end
  // hang guard, well beyond the few thousand cycles the tests take
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    results();
  end
endmodule
